// ---- design/eptb_core.sv ----
/*
  Protection, security and timebase configuration for a 512-byte non-volatile array,
  with the non-volatile configuration copies and their program/erase sequencer.
  Assumes an AXI4-Lite master on clk, a free-running reference clock pin, and the
  latch, program-enable and stop levels driven by logic on clk.
*/
// Behaviour
// - Configuration bits 7:5 are plain read/write storage with no effect.
// - Security bit low means security on, high means off.
// - Security can be switched on by software but never back off.
// - A set block protect bit forbids all program and erase there.
// - Protect bits 0..3 cover 128-byte ranges from 0800 up to 09FF.
// - Unsecured, unprotected blocks allow byte program, byte and block erase; bulk erase needs no block protected.
// - Secured: only byte program and erase; 08F0..08FF fully locked.
// - Every reset copies the non-volatile configuration byte into the shadow.
// - The non-volatile configuration byte uses the normal byte program/erase sequence.
// - An 11-bit divisor in high and low registers sets the timebase.
// - Reset loads both divisor registers from their non-volatile copies.
// - Divider lock bit low freezes divisor registers and their non-volatile copies.
// - Divisor always readable, writable only with latch low and lock disabled.
// - Non-volatile divisor copies use the normal byte program/erase sequence.
// - A cleared non-volatile lock bit reloads as zero on each reset.
// - Wait mode leaves a running sequence untouched.
// - Stop with latch and program-enable set suspends, removes voltage, then restarts the pass from its first tick.
// - Stop with latch or program-enable cleared aborts the sequence at once.
// - Stop mode drives the array to minimum power.
// - Latch captures array writes and holds while a sequence runs.
`timescale 1ns/10ps
`default_nettype none
module eptb_core (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   por_b,
  input  wire eptb_pkg::eptb_axi_req_t axiReq,
  output var  eptb_pkg::eptb_axi_rsp_t axiRsp,
  input  wire logic                   crystalRefClock,
  input  wire logic                   busLatchCtl,
  input  wire logic                   hvProgramEnable,
  input  wire logic                   stopMode,
  input  wire logic                   peStrobe,
  input  wire logic [15:0]            peAddr,
  input  wire logic [7:0]             peData,
  input  wire eptb_pkg::eptb_mode_t    peMode,
  output logic                        timebaseTick,
  output logic                        hvOn,
  output logic                        arrayReady,
  output logic                        arrayPowerDown,
  output logic                        peAllowed
);
  import eptb_pkg::*;

  // Decodes a bus address into a register selector.
  function automatic logic [2:0] regSel(input logic [15:0] a);
    if (a[15:2] == NV_CFG_ADDR[15:2])
      regSel = SEL_NVCFG;
    else if (a[15:2] == ACR_ADDR[15:2])
      regSel = SEL_ACR;
    else if (a[15:2] == DIVH_ADDR[15:2])
      regSel = SEL_DIVH;
    else if (a[15:2] == DIVL_ADDR[15:2])
      regSel = SEL_DIVL;
    else if (a[15:2] == NV_DIVH_ADDR[15:2])
      regSel = SEL_NVDH;
    else if (a[15:2] == NV_DIVL_ADDR[15:2])
      regSel = SEL_NVDL;
    else if (a[15:2] == STAT_ADDR[15:2])
      regSel = SEL_STAT;
    else
      regSel = SEL_NONE;
  endfunction

  // Decides whether a program or erase of the given target may run.
  function automatic logic allowFn(input logic [15:0] a, input eptb_mode_t m,
                                   input logic [7:0] cfg, input logic secd);
    logic byteOp;
    logic secWin;
    byteOp = (m == PE_BYTE_PGM) || (m == PE_BYTE_ERASE);
    secWin = (a >= SEC_LO) && (a <= SEC_HI);
    if ((a >= ARRAY_LO) && (a <= ARRAY_HI))
    begin
      if (m == PE_BULK_ERASE)
        allowFn = (cfg[3:0] == BP_NONE) && cfg[SEC_BIT];
      else if (cfg[a[BLK_MSB:BLK_LSB]])
        allowFn = 1'b0;
      else if (!cfg[SEC_BIT])
        allowFn = byteOp && !secWin;
      else
        allowFn = 1'b1;
    end
    else if (a == NV_CFG_ADDR)
      allowFn = byteOp;
    else if ((a == NV_DIVH_ADDR) || (a == NV_DIVL_ADDR))
      allowFn = byteOp && secd;
    else
      allowFn = 1'b0;
  endfunction

  logic [7:0]  acr_reg;
  logic [7:0]  divH_reg;
  logic [7:0]  divL_reg;
  logic [7:0]  nvCfg_reg;
  logic [7:0]  nvDivH_reg;
  logic [7:0]  nvDivL_reg;
  logic        loadPend_reg;
  logic        awHeld_reg;
  logic        wHeld_reg;
  logic [15:0] awAddr_reg;
  logic [7:0]  wData_reg;
  logic        wStrb0_reg;
  logic        ref1_reg;
  logic        ref2_reg;
  logic        ref3_reg;
  logic        refLvl_reg;
  logic [10:0] divCnt_reg;
  eptb_seq_t   state_reg;
  eptb_seq_t   state_next;
  logic [7:0]  seqTicks_reg;
  logic        pgmPrev_reg;
  logic        capValid_reg;
  logic [15:0] capAddr_reg;
  logic [7:0]  capData_reg;
  eptb_mode_t  capMode_reg;

  // Bus handshake decoding.
  wire         doWrite   = awHeld_reg && wHeld_reg && !axiRsp.bvalid;
  wire [2:0]   wrSel     = regSel(awAddr_reg);
  wire         wrEn      = doWrite && wStrb0_reg && !loadPend_reg;
  wire         awTake    = axiReq.awvalid && axiRsp.awready;
  wire         wTake     = axiReq.wvalid && axiRsp.wready;
  wire         arTake    = axiReq.arvalid && axiRsp.arready;
  wire         awHeld_next = !doWrite && (awHeld_reg || awTake);
  wire         wHeld_next  = !doWrite && (wHeld_reg || wTake);
  wire         bvalid_next = doWrite || (axiRsp.bvalid && !axiReq.bready);
  wire         rvalid_next = arTake || (axiRsp.rvalid && !axiReq.rready);
  wire [2:0]   rdSel     = regSel(axiReq.araddr);

  // The latch is held while a sequence runs, so a late clear cannot drop it.
  wire         latchEff  = busLatchCtl || (state_reg != SEQ_IDLE);
  wire         divWrOk   = !latchEff && divH_reg[SECD_BIT];
  wire [10:0]  divisor   = {divH_reg[2:0], divL_reg};

  // Read data selection; divisor bits read at any time.
  logic [7:0] rdVal;
  always_comb
  begin
    if (rdSel == SEL_NVCFG)
      rdVal = nvCfg_reg;
    else if (rdSel == SEL_ACR)
      rdVal = acr_reg;
    else if (rdSel == SEL_DIVH)
      rdVal = divH_reg;
    else if (rdSel == SEL_DIVL)
      rdVal = divL_reg;
    else if (rdSel == SEL_NVDH)
      rdVal = nvDivH_reg;
    else if (rdSel == SEL_NVDL)
      rdVal = nvDivL_reg;
    else if (rdSel == SEL_STAT)
      rdVal = {3'h0, peAllowed, capValid_reg, hvOn, state_reg};
    else
      rdVal = 8'h00;
  end

  // AXI4-Lite slave: address and data are taken in either order.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHeld_reg     <= 1'b0;
      wHeld_reg      <= 1'b0;
      awAddr_reg     <= 16'h0000;
      wData_reg      <= 8'h00;
      wStrb0_reg     <= 1'b0;
      axiRsp         <= '0;
    end
    else
    begin
      awHeld_reg     <= awHeld_next;
      wHeld_reg      <= wHeld_next;
      if (awTake)
        awAddr_reg   <= axiReq.awaddr;
      if (wTake)
      begin
        wData_reg    <= axiReq.wdata[7:0];
        wStrb0_reg   <= axiReq.wstrb[0];
      end
      axiRsp.awready <= !awHeld_next;
      axiRsp.wready  <= !wHeld_next;
      axiRsp.bvalid  <= bvalid_next;
      if (doWrite)
        axiRsp.bresp <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      axiRsp.arready <= !rvalid_next;
      axiRsp.rvalid  <= rvalid_next;
      if (arTake)
      begin
        axiRsp.rdata <= {24'h000000, rdVal};
        axiRsp.rresp <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // Shadow registers: one load cycle after reset, then software writes.
  // The load is clocked because an async reset may only take constants.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loadPend_reg <= 1'b1;
      acr_reg      <= ACR_RST;
      divH_reg     <= DIV_RST;
      divL_reg     <= DIV_RST;
    end
    else if (loadPend_reg)
    begin
      loadPend_reg <= 1'b0;
      acr_reg      <= nvCfg_reg;
      divH_reg     <= nvDivH_reg & DIVH_WMASK;
      divL_reg     <= nvDivL_reg;
    end
    else if (wrEn)
    begin
      if (wrSel == SEL_ACR)
      begin
        acr_reg[UNU_MSB:UNU_LSB] <= wData_reg[UNU_MSB:UNU_LSB];
        acr_reg[SEC_BIT] <= acr_reg[SEC_BIT] && wData_reg[SEC_BIT];
      end
      if ((wrSel == SEL_DIVH) && divWrOk)
        divH_reg <= wData_reg & DIVH_WMASK;
      if ((wrSel == SEL_DIVL) && divWrOk)
        divL_reg <= wData_reg;
    end
  end

  // Reference clock pin: three stages, a level counts once stages two and three agree.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref1_reg   <= 1'b0;
      ref2_reg   <= 1'b0;
      ref3_reg   <= 1'b0;
      refLvl_reg <= 1'b0;
    end
    else
    begin
      ref1_reg <= crystalRefClock;
      ref2_reg <= ref1_reg;
      ref3_reg <= ref2_reg;
      if (ref2_reg == ref3_reg)
        refLvl_reg <= ref3_reg;
    end
  end

  wire refEdge  = (ref2_reg == ref3_reg) && ref3_reg && !refLvl_reg;
  // A count already past a freshly lowered divisor wraps at the next edge instead of running round.
  wire divWrap  = refEdge && (divisor != 11'h000) && (divCnt_reg >= divisor - 11'h001);

  // Timebase divider; a zero divisor stops the tick rather than ticking every edge.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divCnt_reg   <= 11'h000;
      timebaseTick <= 1'b0;
    end
    else
    begin
      timebaseTick <= divWrap;
      if (divWrap || (refEdge && (divisor == 11'h000)))
        divCnt_reg <= 11'h000;
      else if (refEdge)
        divCnt_reg <= divCnt_reg + 11'h001;
    end
  end

  wire allowNow = allowFn(capAddr_reg, capMode_reg, acr_reg, divH_reg[SECD_BIT]);
  wire seqStart = (state_reg == SEQ_IDLE) && busLatchCtl && hvProgramEnable && !pgmPrev_reg
                  && capValid_reg && allowNow && !stopMode && !loadPend_reg;
  wire bothSet  = busLatchCtl && hvProgramEnable;
  wire seqDone  = (state_reg == SEQ_RUN) && !stopMode && hvProgramEnable && timebaseTick
                  && (seqTicks_reg == PE_SEQ_TICKS - 8'h01);
  wire capInArr = (capAddr_reg >= ARRAY_LO) && (capAddr_reg <= ARRAY_HI);

  // Sequencer next state; wait mode has no input here and so cannot disturb it.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SEQ_IDLE:
        if (seqStart)
          state_next = SEQ_RUN;
      SEQ_RUN:
        if (stopMode && bothSet)
          state_next = SEQ_SUSP;
        else if (stopMode)
          state_next = SEQ_IDLE;
        else if (!hvProgramEnable || seqDone)
          state_next = SEQ_IDLE;
      SEQ_SUSP:
        if (!stopMode)
          state_next = SEQ_RUN;
      default:
        state_next = SEQ_IDLE;
    endcase
  end

  // Sequencer registers and the address capture that the latch enables.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg      <= SEQ_IDLE;
      seqTicks_reg   <= 8'h00;
      pgmPrev_reg    <= 1'b0;
      capValid_reg   <= 1'b0;
      capAddr_reg    <= 16'h0000;
      capData_reg    <= 8'h00;
      capMode_reg    <= PE_BYTE_PGM;
      hvOn           <= 1'b0;
      arrayReady     <= 1'b1;
      arrayPowerDown <= 1'b0;
      peAllowed      <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      pgmPrev_reg    <= hvProgramEnable;
      hvOn           <= (state_next == SEQ_RUN);
      arrayReady     <= (state_next == SEQ_IDLE);
      arrayPowerDown <= stopMode;
      peAllowed      <= capValid_reg && allowNow;
      if (state_next != SEQ_RUN)
        seqTicks_reg <= 8'h00;
      else if (timebaseTick)
        seqTicks_reg <= seqTicks_reg + 8'h01;
      // The last captured write wins; the capture is frozen while a sequence runs.
      if ((state_reg == SEQ_IDLE) && busLatchCtl && peStrobe)
      begin
        capValid_reg <= 1'b1;
        capAddr_reg  <= peAddr;
        capData_reg  <= peData;
        capMode_reg  <= peMode;
      end
      else if ((state_reg == SEQ_IDLE) && !busLatchCtl)
        capValid_reg <= 1'b0;
    end
  end

  // Non-volatile copies keep their value across system reset; only power-on resets them.
  always_ff @(posedge clk or negedge por_b)
  begin
    if (!por_b)
    begin
      nvCfg_reg  <= FACTORY_CFG;
      nvDivH_reg <= NV_BLANK;
      nvDivL_reg <= NV_BLANK;
    end
    else if (seqDone)
    begin
      if (capAddr_reg == NV_CFG_ADDR)
        nvCfg_reg <= (capMode_reg == PE_BYTE_PGM) ? (nvCfg_reg & capData_reg) : NV_BLANK;
      if (capAddr_reg == NV_DIVH_ADDR)
        nvDivH_reg <= (capMode_reg == PE_BYTE_PGM) ? (nvDivH_reg & capData_reg) : NV_BLANK;
      if (capAddr_reg == NV_DIVL_ADDR)
        nvDivL_reg <= (capMode_reg == PE_BYTE_PGM) ? (nvDivL_reg & capData_reg) : NV_BLANK;
    end
  end

  // Checks on the protection, loading, divider and stop behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_unused;
    wrEn && (wrSel == SEL_ACR) |=> acr_reg[UNU_MSB:UNU_LSB] == $past(wData_reg[UNU_MSB:UNU_LSB]);
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits not stored");

  property p_secOnce;
    !acr_reg[SEC_BIT] && !loadPend_reg |=> !acr_reg[SEC_BIT];
  endproperty
  a_secOnce: assert property (p_secOnce) else $error("security turned off");

  property p_protect;
    seqStart && capInArr && (capMode_reg != PE_BULK_ERASE) |-> !acr_reg[capAddr_reg[BLK_MSB:BLK_LSB]];
  endproperty
  a_protect: assert property (p_protect) else $error("protected block started");

  property p_secure;
    seqStart && capInArr && !acr_reg[SEC_BIT] |-> !((capAddr_reg >= SEC_LO) && (capAddr_reg <= SEC_HI))
      && ((capMode_reg == PE_BYTE_PGM) || (capMode_reg == PE_BYTE_ERASE));
  endproperty
  a_secure: assert property (p_secure) else $error("secured operation started");

  // The sampled reset keeps the edge that releases reset from checking the reset values.
  property p_loadCfg;
    rst_b && loadPend_reg |=> acr_reg == $past(nvCfg_reg) && !loadPend_reg;
  endproperty
  a_loadCfg: assert property (p_loadCfg) else $error("configuration not loaded");

  property p_loadDiv;
    rst_b && loadPend_reg |=> divL_reg == $past(nvDivL_reg) && divH_reg == ($past(nvDivH_reg) & DIVH_WMASK);
  endproperty
  a_loadDiv: assert property (p_loadDiv) else $error("divisor not loaded");

  property p_divLock;
    !divH_reg[SECD_BIT] && !loadPend_reg |=> $stable(divH_reg) && $stable(divL_reg);
  endproperty
  a_divLock: assert property (p_divLock) else $error("locked divisor changed");

  property p_divWr;
    wrEn && (wrSel == SEL_DIVL) && divWrOk |=> divL_reg == $past(wData_reg);
  endproperty
  a_divWr: assert property (p_divWr) else $error("divisor write lost");

  property p_tick;
    divWrap |=> timebaseTick && (divCnt_reg == 11'h000) ##1 !timebaseTick;
  endproperty
  a_tick: assert property (p_tick) else $error("timebase tick wrong");

  property p_susp;
    (state_reg == SEQ_RUN) && stopMode && bothSet |=> (state_reg == SEQ_SUSP) && !hvOn && !arrayReady;
  endproperty
  a_susp: assert property (p_susp) else $error("stop did not suspend");

  property p_abort;
    (state_reg == SEQ_RUN) && stopMode && !bothSet |=> (state_reg == SEQ_IDLE) && !hvOn;
  endproperty
  a_abort: assert property (p_abort) else $error("stop did not abort");

  c_start: cover property (seqStart);
  c_susp:  cover property ((state_reg == SEQ_SUSP) ##1 (state_reg == SEQ_RUN));
  c_done:  cover property (seqDone && (capAddr_reg == NV_CFG_ADDR));
  c_tick:  cover property (timebaseTick);
endmodule
`default_nettype wire

// ---- design/eptb_pkg.sv ----
/*
  Package for the array protection and timebase configuration block: register map,
  field positions, reset and factory values, modes, sequencer states and bus carriers.
  Assumes a 16-bit register address space reached over AXI4-Lite with 32-bit data.
*/
`default_nettype none
package eptb_pkg;
  // Register byte addresses; each register takes one aligned word.
  localparam logic [15:0] NV_CFG_ADDR  = 16'hfe1c;
  localparam logic [15:0] ACR_ADDR     = 16'hfe20;
  localparam logic [15:0] DIVH_ADDR    = 16'hfe24;
  localparam logic [15:0] DIVL_ADDR    = 16'hfe28;
  localparam logic [15:0] NV_DIVH_ADDR = 16'hfe2c;
  localparam logic [15:0] NV_DIVL_ADDR = 16'hfe30;
  localparam logic [15:0] STAT_ADDR    = 16'hfe34;
  // Register selector codes returned by the address decoder.
  localparam logic [2:0] SEL_NONE  = 3'h0;
  localparam logic [2:0] SEL_NVCFG = 3'h1;
  localparam logic [2:0] SEL_ACR   = 3'h2;
  localparam logic [2:0] SEL_DIVH  = 3'h3;
  localparam logic [2:0] SEL_DIVL  = 3'h4;
  localparam logic [2:0] SEL_NVDH  = 3'h5;
  localparam logic [2:0] SEL_NVDL  = 3'h6;
  localparam logic [2:0] SEL_STAT  = 3'h7;
  // Array address ranges.
  localparam logic [15:0] ARRAY_LO = 16'h0800;
  localparam logic [15:0] ARRAY_HI = 16'h09ff;
  localparam logic [15:0] SEC_LO   = 16'h08f0;
  localparam logic [15:0] SEC_HI   = 16'h08ff;
  // Field positions.
  localparam int BLK_MSB  = 8;
  localparam int BLK_LSB  = 7;
  localparam int UNU_MSB  = 7;
  localparam int UNU_LSB  = 5;
  localparam int SEC_BIT  = 4;
  localparam int SECD_BIT = 7;
  localparam logic [7:0] DIVH_WMASK = 8'h87;
  // Reset and factory values.
  localparam logic [7:0] FACTORY_CFG = 8'hf0;
  localparam logic [7:0] NV_BLANK    = 8'hff;
  localparam logic [7:0] ACR_RST     = 8'h0f;
  localparam logic [7:0] DIV_RST     = 8'h00;
  localparam logic [3:0] BP_NONE     = 4'h0;
  // Number of timebase ticks one program or erase pass takes.
  localparam logic [7:0] PE_SEQ_TICKS = 8'h08;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PE_BYTE_PGM    = 2'h0,
    PE_BYTE_ERASE  = 2'h1,
    PE_BLOCK_ERASE = 2'h2,
    PE_BULK_ERASE  = 2'h3
  } eptb_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_RUN  = 2'h1,
    SEQ_SUSP = 2'h3
  } eptb_seq_t;

  typedef struct packed {
    logic        awvalid;
    logic [15:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [15:0] araddr;
    logic        rready;
  } eptb_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } eptb_axi_rsp_t;
endpackage
`default_nettype wire

// ---- bench/eptb_core_tb_top.sv ----
/*
  Self-checking bench for eptb_core: register bus, protection decode, sequencer,
  stop handling and timebase divider.
  Assumes eptb_pkg and eptb_core from design/ are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module eptb_core_tb_top;
  import eptb_pkg::*;
  logic          clk = 1'b0;
  logic          rst_b = 1'b0;
  logic          por_b = 1'b0;
  eptb_axi_req_t axiReq = '0;
  eptb_axi_rsp_t axiRsp;
  logic          refClk = 1'b0;
  logic          latch = 1'b0;
  logic          pgm = 1'b0;
  logic          stopMode = 1'b0;
  logic          strobe = 1'b0;
  logic [15:0]   peAddr = 16'h0000;
  logic [7:0]    peData = 8'h00;
  eptb_mode_t    peMode = PE_BYTE_PGM;
  logic          tick, hvOn, ready, pwrDn, allowed;
  logic [31:0]   rd, r;
  logic [1:0]    rs;
  integer        errCount = 0;
  integer        testsRun = 0;
  integer        cyc = 0;
  integer        seed = 32'h7f8d3db6;

  eptb_core eptb_core_inst (.clk(clk), .rst_b(rst_b), .por_b(por_b), .axiReq(axiReq), .axiRsp(axiRsp),
    .crystalRefClock(refClk), .busLatchCtl(latch), .hvProgramEnable(pgm), .stopMode(stopMode),
    .peStrobe(strobe), .peAddr(peAddr), .peData(peData), .peMode(peMode), .timebaseTick(tick),
    .hvOn(hvOn), .arrayReady(ready), .arrayPowerDown(pwrDn), .peAllowed(allowed));

  // The reference runs at a quarter of the system rate, so each level lasts long enough
  // for the pin filter to accept it and one divisor count spans four cycles.
  always #25 clk = ~clk;
  always @(posedge clk) if (cyc[0]) refClk <= ~refClk;

  // A hang is cut short well beyond the few thousand cycles the sequence needs.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errCount = errCount + 1;
      summarize;
    end
  end

  task automatic summarize;
    $display("checks=%0d errors=%0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun = testsRun + 1;
    if (got !== exp)
    begin
      errCount = errCount + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer; valids drop only on the edge that takes them, the answer ends it.
  task automatic axi(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    if (wr)
      axiReq <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {24'h0, d}, wstrb: 4'hf, bready: 1'b1,
                  default: '0};
    else
      axiReq <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    forever
    begin
      @(posedge clk);
      if ((wr && axiRsp.bvalid) || (!wr && axiRsp.rvalid))
      begin
        rd = axiRsp.rdata;
        rs = wr ? axiRsp.bresp : axiRsp.rresp;
        axiReq <= '0;
        break;
      end
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end
  endtask

  task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
    axi(1'b0, a, 8'h00);
    chk({rs, rd[29:0]}, {RESP_OKAY, 22'h0, exp});
  endtask

  task automatic doReset(input logic withPor);
    @(posedge clk);
    rst_b <= 1'b0;
    por_b <= ~withPor;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // Measures the gap between two later ticks, skipping the one disturbed by the divisor change.
  task automatic tickGap(input logic [7:0] dv);
    int k;
    k = 0;
    repeat (3)
    begin
      k = 0;
      @(posedge clk);
      while (tick !== 1'b1 && k < 100)
      begin
        @(posedge clk);
        k++;
      end
    end
    chk(k + 1, 4 * dv);
  endtask

  // Capture, start and finish one sequence; stopKind 1 suspends in stop, 2 aborts.
  task automatic peRun(input logic [15:0] a, input logic [7:0] d, input eptb_mode_t m,
                       input logic expOk, input int stopKind);
    @(posedge clk);
    latch <= 1'b1;
    strobe <= 1'b1;
    peAddr <= a;
    peData <= d;
    peMode <= m;
    @(posedge clk);
    strobe <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, allowed}, {31'h0, expOk});
    pgm <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, hvOn}, {31'h0, expOk});
    if (stopKind == 1)
    begin
      stopMode <= 1'b1;
      repeat (3) @(posedge clk);
      chk({29'h0, hvOn, pwrDn, ready}, 32'h2);
      stopMode <= 1'b0;
      repeat (3) @(posedge clk);
      chk({30'h0, hvOn, pwrDn}, 32'h2);
    end
    if (stopKind == 2)
    begin
      pgm <= 1'b0;
      stopMode <= 1'b1;
      repeat (3) @(posedge clk);
      chk({30'h0, hvOn, ready}, 32'h1);
      stopMode <= 1'b0;
    end
    for (int n = 0; n < 3000 && ready !== 1'b1; n++) @(posedge clk);
    chk({31'h0, ready}, 32'h1);
    pgm <= 1'b0;
    latch <= 1'b0;
  endtask

  // Main sequence: reset values, register access, divider, protection, stop, lock.
  initial
  begin
    doReset(1'b1);
    rdChk(ACR_ADDR, FACTORY_CFG);
    rdChk(DIVH_ADDR, NV_BLANK & DIVH_WMASK);
    rdChk(DIVL_ADDR, NV_BLANK);
    axi(1'b0, 16'hfe40, 8'h00);
    chk({rs, rd[29:0]}, {RESP_SLVERR, 30'h0});
    axi(1'b1, 16'hfe40, 8'h55);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      axi(1'b1, ACR_ADDR, {r[7:5], 1'b1, r[3:0]});
      rdChk(ACR_ADDR, {r[7:5], 5'h10});
    end
    for (int i = 0; i < 3; i++)
    begin
      r = $random(seed);
      axi(1'b1, DIVH_ADDR, {1'b1, 4'h0, r[10:8]});
      axi(1'b1, DIVL_ADDR, r[7:0]);
      rdChk(DIVH_ADDR, {1'b1, 4'h0, r[10:8]});
      rdChk(DIVL_ADDR, r[7:0]);
      axi(1'b1, DIVH_ADDR, 8'h80);
      axi(1'b1, DIVL_ADDR, {5'h0, r[14:12]} + 8'h02);
      tickGap({5'h0, r[14:12]} + 8'h02);
    end
    // Divisor for a notional 114 kHz reference, rounded as software must; small to keep sequences short.
    axi(1'b1, DIVL_ADDR, 8'h04);
    latch <= 1'b1;
    axi(1'b1, DIVL_ADDR, 8'h33);
    latch <= 1'b0;
    rdChk(DIVL_ADDR, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      peRun({7'h04, r[8:0]}, r[15:8], eptb_mode_t'(i[1:0]), 1'b1, 0);
    end
    peRun(NV_CFG_ADDR, 8'h00, PE_BYTE_ERASE, 1'b1, 0);
    peRun(NV_CFG_ADDR, 8'hf5, PE_BYTE_PGM, 1'b1, 0);
    rdChk(NV_CFG_ADDR, 8'hf5);
    peRun(NV_DIVL_ADDR, 8'h04, PE_BYTE_PGM, 1'b1, 0);
    peRun(NV_DIVH_ADDR, 8'h80, PE_BYTE_PGM, 1'b1, 0);
    rdChk(NV_DIVH_ADDR, 8'h80);
    doReset(1'b0);
    rdChk(ACR_ADDR, 8'hf5);
    rdChk(DIVL_ADDR, 8'h04);
    peRun(16'h087f, 8'h00, PE_BYTE_PGM, 1'b0, 0);
    peRun(16'h0880, 8'h00, PE_BYTE_ERASE, 1'b1, 0);
    peRun(16'h097f, 8'h00, PE_BLOCK_ERASE, 1'b0, 0);
    peRun(16'h0980, 8'h00, PE_BLOCK_ERASE, 1'b1, 0);
    peRun(16'h09ff, 8'h00, PE_BULK_ERASE, 1'b0, 0);
    axi(1'b1, ACR_ADDR, 8'h00);
    rdChk(ACR_ADDR, 8'h05);
    axi(1'b1, ACR_ADDR, 8'h10);
    rdChk(ACR_ADDR, 8'h05);
    peRun(16'h08f0, 8'h00, PE_BYTE_PGM, 1'b0, 0);
    peRun(16'h08ff, 8'h00, PE_BYTE_ERASE, 1'b0, 0);
    peRun(16'h08ef, 8'h00, PE_BYTE_ERASE, 1'b1, 0);
    peRun(16'h08ef, 8'h00, PE_BLOCK_ERASE, 1'b0, 0);
    peRun(16'h0980, 8'h00, PE_BYTE_PGM, 1'b1, 1);
    peRun(16'h0980, 8'h00, PE_BYTE_ERASE, 1'b1, 2);
    doReset(1'b0);
    peRun(NV_DIVH_ADDR, 8'h7f, PE_BYTE_PGM, 1'b1, 0);
    doReset(1'b0);
    rdChk(DIVH_ADDR, 8'h00);
    axi(1'b1, DIVL_ADDR, 8'h09);
    rdChk(DIVL_ADDR, 8'h04);
    axi(1'b1, DIVH_ADDR, 8'h87);
    rdChk(DIVH_ADDR, 8'h00);
    peRun(NV_DIVH_ADDR, 8'h00, PE_BYTE_ERASE, 1'b0, 0);
    doReset(1'b0);
    rdChk(DIVH_ADDR, 8'h00);
    summarize;
  end
endmodule
`default_nettype wire
